// ==== core/sleep_mode_controller.sv ====
`include "sleep_defs.svh"
module sleep_mode_controller
    import sleep_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ctrlWrite,
    input  wire logic [7:0]   ctrlWriteData,
    input  wire logic         sleepInstr,
    input  wire logic         irqPending,
    input  wire logic         globalIrqEnable,
    input  wire logic         timer2IrqEnable,
    input  wire logic         timer2_async_clocking,
    input  wire logic         converterEnabled,
    input  wire logic         crystalSource,
    input  wire logic [3:0]   clock_source_fuses,
    input  wire logic [1:0]   startupFuses,
    input  wire logic         anyReset,
    input  wire wake_events_t wakeEventsPin,
    output logic [7:0]        mcu_control_reg,
    output clock_gates_t      clockRun_reg,
    output logic              sleeping_reg,
    output logic              holdPc_reg,
    output logic              irqDispatch_reg,
    output logic              resetVector_reg,
    output logic              convStart_reg
);
    sleep_state_t state_reg;
    sleep_state_t state_next;
    wake_events_t wakeMeta_reg;
    wake_events_t wakeSync_reg;
    logic [2:0]   mode_reg;
    logic [7:0]   ctrl_reg;
    logic         enable;
    logic [2:0]   modeSel;
    logic [2:0]   effMode;
    logic         modeLegal;
    logic         enterSleep;
    logic         deepMode;
    logic         asyncMode;
    logic         standbyMode;
    logic         wakeLines;
    logic         wakeTimer2;
    logic         wakeIdle;
    logic         wakeNoise;
    logic         wakeDeep;
    logic         wake;
    logic [7:0]   startupCycles;
    logic [7:0]   startValue;
    logic         cntLoad;
    logic [7:0]   cntValue;
    logic         cntDone;
    clock_gates_t gates_next;

    // Control byte fields
    assign enable  = ctrl_reg[`CTRL_ENABLE_BIT];
    assign modeSel = {ctrl_reg[`CTRL_MODE_HI_BIT], ctrl_reg[`CTRL_MODE_MID_BIT],
                      ctrl_reg[`CTRL_MODE_LO_BIT]};

    // Reserved codes and standby without crystal do not enter sleep
    assign modeLegal = (modeSel == `MODE_IDLE) || (modeSel == `MODE_NOISE_RED)
                    || (modeSel == `MODE_POWER_DOWN) || (modeSel == `MODE_POWER_SAVE)
                    || (crystalSource && (modeSel == `MODE_STANDBY
                                          || modeSel == `MODE_EXT_STANDBY));
    assign enterSleep = (state_reg == ST_RUN) && sleepInstr && enable && modeLegal;
    // Latched mode lags by one edge, so entry uses the fresh selection
    assign effMode    = enterSleep ? modeSel : mode_reg;

    assign deepMode    = (mode_reg == `MODE_POWER_DOWN) || (mode_reg == `MODE_POWER_SAVE)
                      || (mode_reg == `MODE_STANDBY) || (mode_reg == `MODE_EXT_STANDBY);
    assign asyncMode   = (mode_reg == `MODE_POWER_SAVE) || (mode_reg == `MODE_EXT_STANDBY);
    assign standbyMode = (mode_reg == `MODE_STANDBY) || (mode_reg == `MODE_EXT_STANDBY);

    // Edge events on lines 0/1 count only in Idle
    assign wakeLines  = wakeSync_reg.extLevel0 || wakeSync_reg.extLevel1
                     || wakeSync_reg.extLine2 || wakeSync_reg.addrMatch;
    assign wakeTimer2 = wakeSync_reg.timer2Irq;
    assign wakeIdle   = wakeLines || wakeTimer2 || wakeSync_reg.extEdge0
                     || wakeSync_reg.extEdge1 || wakeSync_reg.convDone
                     || wakeSync_reg.memReady || wakeSync_reg.otherIo;
    assign wakeNoise  = wakeLines || wakeTimer2 || wakeSync_reg.convDone
                     || wakeSync_reg.memReady;
    assign wakeDeep   = wakeLines || (asyncMode && timer2_async_clocking && wakeTimer2
                                      && timer2IrqEnable && globalIrqEnable);

    always_comb
    begin
        wake = wakeDeep;
        if (mode_reg == `MODE_IDLE)
            wake = wakeIdle;
        else if (mode_reg == `MODE_NOISE_RED)
            wake = wakeNoise;
    end

    // Start-up after oscillator stop follows the clock source fuses
    always_comb
    begin
        startupCycles = `STARTUP_6CK;
        if (clock_source_fuses >= `FUSE_RC_EXT_FIRST && clock_source_fuses <= `FUSE_RC_EXT_LAST
            && startupFuses != `FUSE_SUT_SHORT)
            startupCycles = `STARTUP_18CK;
    end

    always_comb
    begin
        startValue = `IRQ_HALT_CYCLES;
        if (standbyMode)
            startValue = `STANDBY_WAKE_CYCLES;
        else if (deepMode || mode_reg == `MODE_NOISE_RED)
            startValue = startupCycles;
    end

    assign cntLoad  = (state_reg == ST_SLEEP && wake)
                   || (state_reg == ST_START && cntDone);
    assign cntValue = (state_reg == ST_SLEEP) ? startValue : `IRQ_HALT_CYCLES;

    wake_counter u_wake_counter (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .load      (cntLoad),
        .loadValue (cntValue),
        .done      (cntDone)
    );

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN:
                if (enterSleep)
                    state_next = ST_SLEEP;
            ST_SLEEP:
                if (wake)
                    state_next = (deepMode || mode_reg == `MODE_NOISE_RED)
                               ? ST_START : ST_HALT;
            ST_START:
                if (cntDone)
                    state_next = ST_HALT;
            ST_HALT:
                if (cntDone)
                    state_next = ST_RUN;
        endcase
    end

    // Clock gating per mode; Idle skips start-up since oscillator runs
    always_comb
    begin
        gates_next = '{core: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1,
                       async: 1'b1, mainOsc: 1'b1};
        if (state_next == ST_SLEEP)
        begin
            gates_next.core  = 1'b0;
            gates_next.flash = 1'b0;
            if (effMode != `MODE_IDLE)
                gates_next.io = 1'b0;
            if (effMode > `MODE_NOISE_RED)
            begin
                gates_next.conv    = 1'b0;
                gates_next.async   = (effMode == `MODE_POWER_SAVE
                                   || effMode == `MODE_EXT_STANDBY)
                                   && timer2_async_clocking;
                gates_next.mainOsc = (effMode == `MODE_STANDBY)
                                   || (effMode == `MODE_EXT_STANDBY);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        wakeMeta_reg <= wakeEventsPin;
        wakeSync_reg <= wakeMeta_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ctrl_reg <= `CTRL_RESET_VALUE;
        else if (ctrlWrite)
            ctrl_reg <= ctrlWriteData;
    end

    // Mode is latched at entry so later writes cannot change sleep behaviour
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mode_reg <= `MODE_IDLE;
        else if (enterSleep)
            mode_reg <= modeSel;
    end

    // Gated clocks mean register file and memory hold their values
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg    <= ST_RUN;
            clockRun_reg <= '{core: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1,
                              async: 1'b1, mainOsc: 1'b1};
        end
        else
        begin
            state_reg    <= state_next;
            clockRun_reg <= gates_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sleeping_reg    <= 1'b0;
            holdPc_reg      <= 1'b0;
            irqDispatch_reg <= 1'b0;
            convStart_reg   <= 1'b0;
            mcu_control_reg <= `CTRL_RESET_VALUE;
        end
        else
        begin
            sleeping_reg    <= (state_next == ST_SLEEP);
            holdPc_reg      <= (state_next != ST_RUN);
            irqDispatch_reg <= (state_reg == ST_HALT) && cntDone && irqPending;
            convStart_reg   <= enterSleep && converterEnabled
                            && (modeSel == `MODE_IDLE || modeSel == `MODE_NOISE_RED);
            mcu_control_reg <= ctrlWrite ? ctrlWriteData : ctrl_reg;
        end
    end

    // Reset while asleep restarts from the reset vector
    always_ff @(posedge ref_clk)
    begin
        if (rst || anyReset)
            resetVector_reg <= anyReset && (state_reg != ST_RUN);
        else
            resetVector_reg <= 1'b0;
    end
endmodule

// ==== core/sleep_defs.svh ====
`ifndef SLEEP_DEFS_SVH
`define SLEEP_DEFS_SVH
`define CTRL_MODE_HI_BIT    7
`define CTRL_ENABLE_BIT     6
`define CTRL_MODE_MID_BIT   5
`define CTRL_MODE_LO_BIT    4
`define CTRL_RESET_VALUE    8'h00
`define MODE_IDLE           3'h0
`define MODE_NOISE_RED      3'h1
`define MODE_POWER_DOWN     3'h2
`define MODE_POWER_SAVE     3'h3
`define MODE_STANDBY        3'h6
`define MODE_EXT_STANDBY    3'h7
`define IRQ_HALT_CYCLES     8'h04
`define STANDBY_WAKE_CYCLES 8'h06
`define STARTUP_6CK         8'h06
`define STARTUP_18CK        8'h12
`define FUSE_EXT_CLOCK      4'h0
`define FUSE_RC_INT_LAST    4'h4
`define FUSE_RC_EXT_FIRST   4'h5
`define FUSE_RC_EXT_LAST    4'h8
`define FUSE_SUT_SHORT      2'h3
`endif

// ==== core/sleep_pkg.sv ====
package sleep_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} sleep_state_t;

    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic conv;
        logic async;
        logic mainOsc;
    } clock_gates_t;

    typedef struct packed {
        logic extLevel0;
        logic extLevel1;
        logic extEdge0;
        logic extEdge1;
        logic extLine2;
        logic addrMatch;
        logic timer2Irq;
        logic convDone;
        logic memReady;
        logic otherIo;
    } wake_events_t;
endpackage

// ==== core/wake_counter.sv ====
`include "sleep_defs.svh"
module wake_counter
    import sleep_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [7:0] loadValue,
    output logic            done
);
    logic [7:0] count_reg;

    assign done = (count_reg == 8'h01);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_reg <= 8'h00;
        else if (load)
            count_reg <= loadValue;
        else if (count_reg != 8'h00)
            count_reg <= count_reg - 8'h01;
    end
endmodule

// ==== dv/sleep_mode_controller_chk.sv ====
module sleep_mode_controller_chk
    import sleep_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire logic         ctrlWrite,
    input wire logic [7:0]   ctrlWriteData,
    input wire logic         sleepInstr,
    input wire logic         converterEnabled,
    input wire logic         crystalSource,
    input wire logic [7:0]   mcu_control_reg,
    input wire clock_gates_t clockRun_reg,
    input wire logic         sleeping_reg,
    input wire logic         holdPc_reg,
    input wire logic         resetVector_reg,
    input wire logic         convStart_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_halt;
        holdPc_reg[*4];
    endsequence
    a_ctrl_follow: assert property (ctrlWrite |=> mcu_control_reg == $past(ctrlWriteData))
        else $error("control byte not loaded");
    a_no_enable: assert property (sleepInstr && !mcu_control_reg[6] && !holdPc_reg |=> !sleeping_reg)
        else $error("sleep without enable");
    a_reserved_mode: assert property (sleepInstr && !holdPc_reg
        && mcu_control_reg[7:5] == 3'b110 |=> !sleeping_reg)
        else $error("reserved mode slept");
    a_standby_xtal: assert property (sleepInstr && !holdPc_reg && !crystalSource
        && mcu_control_reg[7:5] == 3'b111 |=> !sleeping_reg)
        else $error("standby without crystal");
    a_pd_gates: assert property ($rose(sleeping_reg)
        && $past(mcu_control_reg[7:4]) == 4'h6 |-> clockRun_reg == 6'h00)
        else $error("power-down clocks wrong");
    a_sleep_holds: assert property (sleeping_reg |-> holdPc_reg && !clockRun_reg.core)
        else $error("core active in sleep");
    a_halt_four: assert property ($fell(sleeping_reg) && !resetVector_reg
        && !$past(resetVector_reg) |-> s_halt)
        else $error("halt shorter than four");
    a_conv_start: assert property ($rose(sleeping_reg) && $past(converterEnabled)
        && $past(mcu_control_reg[7:5]) == 3'b010 |-> convStart_reg)
        else $error("no conversion start");
endmodule

bind sleep_mode_controller sleep_mode_controller_chk u_sleep_mode_controller_chk (
    .ref_clk(ref_clk), .rst(rst), .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData),
    .sleepInstr(sleepInstr), .converterEnabled(converterEnabled),
    .crystalSource(crystalSource), .mcu_control_reg(mcu_control_reg),
    .clockRun_reg(clockRun_reg), .sleeping_reg(sleeping_reg), .holdPc_reg(holdPc_reg),
    .resetVector_reg(resetVector_reg), .convStart_reg(convStart_reg));

// ==== dv/wake_source.sv ====
module wake_source
    import sleep_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         fire,
    input  wire logic         drop,
    input  wire wake_events_t ev,
    input  wire logic         holdPc,
    output wake_events_t      wakeEventsPin,
    output logic              irqPending
);
    wake_events_t evReg;
    logic         holdSeen;
    // Level held until the core resumes, so the synchroniser cannot miss it
    always_ff @(posedge ref_clk)
    begin
        holdSeen <= holdPc;
        if (rst || drop || (holdSeen && !holdPc))
            evReg <= '0;
        else if (fire)
            evReg <= ev;
    end
    assign wakeEventsPin = evReg;
    assign irqPending    = |evReg;
endmodule

// ==== dv/test_sleep_mode_controller.sv ====
`include "sleep_defs.svh"
module test_sleep_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic         ctrlWrite = 1'b0;
    logic [7:0]   ctrlWriteData = 8'h00;
    logic         sleepInstr = 1'b0;
    logic         globalIrqEnable = 1'b1;
    logic         crystalSource = 1'b0;
    logic         convOn = 1'b1;
    logic         anyReset = 1'b0;
    logic         fire = 1'b0;
    logic         drop = 1'b0;
    wake_events_t ev = '0;
    wake_events_t wakeEventsPin;
    clock_gates_t clockRun_reg;
    logic [7:0]   mcu_control_reg;
    logic         irqPending, sleeping_reg, holdPc_reg, irqDispatch_reg, resetVector_reg;
    logic         convStart_reg;
    int           fails = 0;
    int           num_checks = 0;
    int           cycles = 0;
    logic [2:0]   modeTab [6] = '{`MODE_IDLE, `MODE_NOISE_RED, `MODE_POWER_DOWN,
                                  `MODE_POWER_SAVE, `MODE_STANDBY, `MODE_EXT_STANDBY};
    logic [5:0]   gateTab [6] = '{6'h0F, 6'h07, 6'h00, 6'h02, 6'h01, 6'h03};

    sleep_mode_controller u_sleep_mode_controller (.ref_clk(ref_clk), .rst(rst),
        .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData), .sleepInstr(sleepInstr),
        .irqPending(irqPending), .globalIrqEnable(globalIrqEnable), .timer2IrqEnable(1'b1),
        .timer2_async_clocking(1'b1), .converterEnabled(convOn),
        .crystalSource(crystalSource), .clock_source_fuses(4'h5), .startupFuses(2'h0),
        .anyReset(anyReset), .wakeEventsPin(wakeEventsPin), .mcu_control_reg(mcu_control_reg),
        .clockRun_reg(clockRun_reg), .sleeping_reg(sleeping_reg), .holdPc_reg(holdPc_reg),
        .irqDispatch_reg(irqDispatch_reg), .resetVector_reg(resetVector_reg),
        .convStart_reg(convStart_reg));
    wake_source u_wake_source (.ref_clk(ref_clk), .rst(rst), .fire(fire), .drop(drop),
        .ev(ev), .holdPc(holdPc_reg), .wakeEventsPin(wakeEventsPin), .irqPending(irqPending));

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic set_ctrl(input logic [2:0] m, input logic en);
        @(posedge ref_clk);
        ctrlWrite     <= 1'b1;
        ctrlWriteData <= {m[2], en, m[1:0], 4'h0};
        @(posedge ref_clk);
        ctrlWrite     <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        step();
        check(mcu_control_reg, `CTRL_RESET_VALUE);
        check({1'b0, sleeping_reg, clockRun_reg}, 8'h3F);
    endtask

    // Expected is {asleep, gates}; a refused entry leaves every clock running
    task automatic enter(input logic [2:0] m, input logic en, input logic [6:0] exp);
        logic conv;
        set_ctrl(m, en);
        @(posedge ref_clk);
        sleepInstr <= 1'b1;
        @(posedge ref_clk);
        sleepInstr <= 1'b0;
        #1;
        conv = convStart_reg;
        step();
        conv = conv | convStart_reg;
        check({1'b0, sleeping_reg, clockRun_reg}, {1'b0, exp});
        if (exp[6])
            check({7'h0, conv}, {7'h0, convOn && (m < 3'h2)});
    endtask

    task automatic wake(input wake_events_t e, input logic expWake);
        logic disp;
        disp = 1'b0;
        @(posedge ref_clk);
        fire <= 1'b1;
        ev   <= e;
        @(posedge ref_clk);
        fire <= 1'b0;
        for (int n = 0; n < 60 && holdPc_reg; n++)
        begin
            step();
            disp = disp | irqDispatch_reg;
        end
        check({7'h0, !holdPc_reg}, {7'h0, expWake});
        check({7'h0, disp}, {7'h0, expWake});
        @(posedge ref_clk);
        drop <= !expWake;
        @(posedge ref_clk);
        drop <= 1'b0;
        if (expWake)
            set_ctrl(`MODE_IDLE, 1'b0);
    endtask

    task automatic end_of_test();
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    initial
    begin
        do_reset();
        enter(`MODE_POWER_DOWN, 1'b0, 7'h3F);
        enter(3'h4, 1'b1, 7'h3F);
        enter(3'h5, 1'b1, 7'h3F);
        enter(`MODE_STANDBY, 1'b1, 7'h3F);
        @(posedge ref_clk);
        crystalSource <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            enter(modeTab[i], 1'b1, {1'b1, gateTab[i]});
            wake(10'h010, 1'b1);
        end
        enter(`MODE_IDLE, 1'b1, 7'h4F);
        wake(10'h001, 1'b1);
        @(posedge ref_clk);
        convOn <= 1'b0;
        enter(`MODE_IDLE, 1'b1, 7'h4F);
        wake(10'h010, 1'b1);
        @(posedge ref_clk);
        convOn <= 1'b1;
        enter(`MODE_NOISE_RED, 1'b1, 7'h47);
        wake(10'h001, 1'b0);
        wake(10'h004, 1'b1);
        enter(`MODE_POWER_DOWN, 1'b1, 7'h40);
        wake(10'h080, 1'b0);
        wake(10'h200, 1'b1);
        @(posedge ref_clk);
        globalIrqEnable <= 1'b0;
        enter(`MODE_POWER_SAVE, 1'b1, 7'h42);
        wake(10'h008, 1'b0);
        @(posedge ref_clk);
        globalIrqEnable <= 1'b1;
        wake(10'h008, 1'b1);
        enter(`MODE_POWER_DOWN, 1'b1, 7'h40);
        @(posedge ref_clk);
        anyReset <= 1'b1;
        for (int n = 0; n < 8 && !resetVector_reg; n++)
            step();
        check({7'h0, resetVector_reg}, 8'h01);
        @(posedge ref_clk);
        anyReset <= 1'b0;
        do_reset();
        end_of_test();
    end
endmodule
